// ### logic/gpio_bank.sv
// Parallel I/O port bank with per-pin direction, latch, function, drive type and pull-up.
// Assumes a classic Wishbone master on clk_i and pads that resolve drive and pull-up.
// Contract
// RULE1: Eight ports, forty pins, per-pin direction.
// RULE2: Output latch holds last written data.
// RULE3: Input reads are unlatched live pin levels.
// RULE4: Pins sampled during the read access; the code returns levels sampled two cycles before the answer.
// RULE5: Written data reaches pins next cycle.
// RULE6: Output mode drives the output latch bit.
// RULE7: Pin-state register returns current pin levels.
// RULE8: Direction bit zero input, one output.
// RULE9: Function bit one routes peripheral output.
// RULE10: Output-type bit selects push-pull or open-drain.
// RULE11: Pull-up in input or open-drain mode.
// RULE12: Oscillator pins of first port unusable; pin-state reads still return their levels.
// RULE13: Port P1 carries reset, interrupts, stop.
// RULE14: Port P2 serial routing by select field.
// RULE15: UART swap exchanges transmit and receive pins.
// RULE16: Port P4 feeds analog and key wakeup.
//
// The register addresses and the Wishbone slave port were decided locally.
module gpio_bank (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Pads, port index 0..7 = P0,P1,P2,P4,P7,P8,P9,PB
  input wire logic [63:0] pin_i,
  output logic [63:0] pin_o,
  output logic [63:0] pin_oe_o,
  output logic [63:0] pin_pullup_o,
  // Secondary function outputs and enables from peripherals
  input wire logic [63:0] alt_out_i,
  input wire logic [63:0] alt_oe_i,
  // Serial peripheral signals for port P2
  input wire logic uart_txd_i,
  output logic uart_rxd_o,
  input wire logic serial_out_pin_i,
  input wire logic serial_clock_pin_i,
  input wire logic serial_clock_oe_i,
  output logic serial_in_pin_o,
  output logic serial_clock_pin_o,
  input wire logic twowire_clock_pin_i,
  input wire logic twowire_data_pin_i,
  output logic twowire_clock_pin_o,
  output logic twowire_data_pin_o,
  // Port P1 and P4 secondary inputs
  output logic ext_reset_n_o,
  output logic ext_irq_a_o,
  output logic ext_irq_b_o,
  output logic ext_irq_f_o,
  output logic stop_release_o,
  output logic [7:0] analog_in_o,
  output logic [7:0] key_wakeup_o
);

  // ==========================================================================
  // Pin synchronisers
  // Every pad level passes two flip-flops before any logic reads it.
  // A pin read therefore shows the level of two cycles before the answer.
  // Nothing is latched beyond these stages, so a read is always live.
  // Software that needs a stable value must read the port more than once.
  logic [63:0] pin_meta_q;
  logic [63:0] pin_sync_q;

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      pin_meta_q <= pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ==========================================================================
  // Bus decode
  wire req = cyc_i && stb_i && !ack_o && !err_o;
  wire [2:0] port_idx = adr_i[7:5];
  wire [4:0] reg_ofs = adr_i[4:0];
  wire in_ports = (adr_i[31:8] == 24'h000000);
  wire hit_serial = (adr_i[31:0] == {23'h000000, gpio_bank_pkg::OFS_SERIAL_PIN_SELECT});
  wire hit_uart = (adr_i[31:0] == {23'h000000, gpio_bank_pkg::OFS_UART_PIN_CONFIG});
  wire hit_port;
  assign hit_port = in_ports && (reg_ofs <= gpio_bank_pkg::OFS_PULLUP_SELECT)
                    && (reg_ofs[1:0] == 2'h0);
  wire mapped = hit_port || hit_serial || hit_uart;
  wire wr_lane0 = req && we_i && sel_i[0];

  // ==========================================================================
  // Write strobes
  // One strobe per register, each fired only by an accepted lane-0 write.
  // A write with lane 0 disabled is answered but stores nothing.
  // The strobes are mutually exclusive, since each decodes a single offset.
  wire wr_port = ce_i && wr_lane0 && hit_port;
  wire wr_out_data = wr_port && (reg_ofs == gpio_bank_pkg::OFS_OUTPUT_DATA);
  wire wr_dir = wr_port && (reg_ofs == gpio_bank_pkg::OFS_DIRECTION);
  wire wr_func = wr_port && (reg_ofs == gpio_bank_pkg::OFS_FUNCTION_SELECT);
  wire wr_otype = wr_port && (reg_ofs == gpio_bank_pkg::OFS_OUTPUT_TYPE);
  wire wr_pullup = wr_port && (reg_ofs == gpio_bank_pkg::OFS_PULLUP_SELECT);
  wire wr_serial = ce_i && wr_lane0 && hit_serial;
  wire wr_uart = ce_i && wr_lane0 && hit_uart;

  // ==========================================================================
  // Port registers
  // Bits that a port does not implement are dropped on write and read as zero.
  // The output latch keeps its value in input mode, so a later switch to
  // output mode drives the last written data and not a stale pin level.
  logic [7:0] out_data_q [8];
  logic [7:0] dir_q [8];
  logic [7:0] func_q [8];
  logic [7:0] otype_q [8];
  logic [7:0] pullup_q [8];
  logic [2:0] serial_sel_q;
  logic uart_swap_q;

  wire [7:0] wmask = gpio_bank_pkg::PORT_MASKS[port_idx*8 +: 8];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 8; p++) begin
        out_data_q[p] <= gpio_bank_pkg::RST_PORT;
        dir_q[p] <= gpio_bank_pkg::RST_PORT;
        func_q[p] <= gpio_bank_pkg::RST_PORT;
        otype_q[p] <= gpio_bank_pkg::RST_PORT;
        pullup_q[p] <= gpio_bank_pkg::RST_PORT;
      end
      serial_sel_q <= gpio_bank_pkg::RST_SERIAL;
      uart_swap_q <= gpio_bank_pkg::RST_SWAP;
    end else begin
      if (wr_out_data) begin
        out_data_q[port_idx] <= dat_i[7:0] & wmask; // RULE2
      end
      if (wr_dir) begin
        dir_q[port_idx] <= dat_i[7:0] & wmask; // RULE1
      end
      if (wr_func) begin
        func_q[port_idx] <= dat_i[7:0] & wmask;
      end
      if (wr_otype) begin
        otype_q[port_idx] <= dat_i[7:0] & wmask;
      end
      if (wr_pullup) begin
        pullup_q[port_idx] <= dat_i[7:0] & wmask;
      end
      if (wr_serial) begin
        serial_sel_q <= dat_i[2:0];
      end
      if (wr_uart) begin
        uart_swap_q <= dat_i[gpio_bank_pkg::UART_SWAP_BIT];
      end
    end
  end

  // ==========================================================================
  // Read data and acknowledge. Pin state is taken from the synchronisers, not from the pads.
  // The pin-state offset has no storage behind it: writes to it are answered
  // and ignored, and reads return the synchronised pad levels.
  // Unimplemented bits are masked so that floating pads never read back.
  logic [7:0] port_rd;
  always_comb begin
    port_rd = 8'h00;
    if (reg_ofs == gpio_bank_pkg::OFS_OUTPUT_DATA) begin
      port_rd = out_data_q[port_idx];
    end else if (reg_ofs == gpio_bank_pkg::OFS_PIN_STATE) begin
      port_rd = pin_sync_q[port_idx*8 +: 8] & wmask; // RULE3 RULE4 RULE7
    end else if (reg_ofs == gpio_bank_pkg::OFS_DIRECTION) begin
      port_rd = dir_q[port_idx];
    end else if (reg_ofs == gpio_bank_pkg::OFS_FUNCTION_SELECT) begin
      port_rd = func_q[port_idx];
    end else if (reg_ofs == gpio_bank_pkg::OFS_OUTPUT_TYPE) begin
      port_rd = otype_q[port_idx];
    end else if (reg_ofs == gpio_bank_pkg::OFS_PULLUP_SELECT) begin
      port_rd = pullup_q[port_idx];
    end
  end

  // Only one of the three hits can be true, so the order below is free.
  wire [31:0] rd_word = hit_port ? {24'h000000, port_rd}
                      : hit_serial ? {29'h00000000, serial_sel_q}
                      : hit_uart ? {31'h00000000, uart_swap_q} : 32'h00000000;

  // The answer comes one cycle after the request is taken and lasts one cycle.
  // A pending answer blocks a take only in its own cycle, so a held request is taken every other cycle.
  // Read data is zero outside a read answer, which keeps the bus quiet.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
      dat_o <= (req && mapped && !we_i) ? rd_word : 32'h00000000;
    end
  end

  // ==========================================================================
  // Port P2 serial routing.
  // The UART owns the lower two pins; the swap bit exchanges transmit and
  // receive between them. The clocked serial link sits either on the upper
  // pins or on the lower three, and the two-wire bus on pins 4 and 5.
  // The two-wire lines are open drain: they are only ever driven low.
  // The group bit stops the UART and the lower serial link from driving this port.
  wire [1:0] srf = serial_sel_q[gpio_bank_pkg::SRF_LSB +: 2];
  wire on_p2 = !serial_sel_q[gpio_bank_pkg::SRG_BIT];
  wire uart_mode = !srf[1];
  wire clk_mode = (srf == gpio_bank_pkg::SRF_CLOCKED);
  wire alt_mode = (srf == gpio_bank_pkg::SRF_ALT);
  wire twowire_mode = !srf[0];
  wire [7:0] p2_pins = pin_sync_q[23:16];
  wire [1:0] tx_pin = uart_swap_q ? 2'h1 : 2'h0; // RULE15

  logic [7:0] p2_alt;
  logic [7:0] p2_alt_oe;
  always_comb begin
    p2_alt = alt_out_i[23:16];
    p2_alt_oe = alt_oe_i[23:16];
    if (on_p2 && uart_mode) begin // RULE14
      p2_alt[tx_pin] = uart_txd_i;
      p2_alt_oe[tx_pin] = 1'b1;
    end
    if (clk_mode) begin
      p2_alt[5] = serial_clock_pin_i;
      p2_alt_oe[5] = serial_clock_oe_i;
      p2_alt[3] = serial_out_pin_i;
      p2_alt_oe[3] = 1'b1;
    end else if (twowire_mode) begin
      p2_alt[5] = 1'b0;
      p2_alt_oe[5] = !twowire_clock_pin_i;
      p2_alt[4] = 1'b0;
      p2_alt_oe[4] = !twowire_data_pin_i;
    end
    if (on_p2 && alt_mode) begin
      p2_alt[2] = serial_clock_pin_i;
      p2_alt_oe[2] = serial_clock_oe_i;
      p2_alt[0] = serial_out_pin_i;
      p2_alt_oe[0] = 1'b1;
    end
  end

  assign uart_rxd_o = p2_pins[uart_swap_q ? 0 : 1];
  assign serial_in_pin_o = clk_mode ? p2_pins[4] : p2_pins[1];
  assign serial_clock_pin_o = clk_mode ? p2_pins[5] : p2_pins[2];
  assign twowire_clock_pin_o = p2_pins[5];
  assign twowire_data_pin_o = p2_pins[4];

  // ==========================================================================
  // Pad drive: one slice per port.
  // The function bit picks between the peripheral and the output latch.
  // A pin drives only in output mode; an open-drain pin drives only a low.
  // The pull-up is offered in input mode and in open-drain mode, never
  // against a push-pull driver.
  // The oscillator pins of the first port are never driven or pulled up.
  for (genvar p = 0; p < 8; p++) begin : g_port
    wire [7:0] msk = gpio_bank_pkg::PORT_MASKS[p*8 +: 8]
                     & ((p == 0) ? ~gpio_bank_pkg::OSC_RESERVED : 8'hFF); // RULE12
    wire [7:0] aval = (p == 2) ? p2_alt : alt_out_i[p*8 +: 8];
    wire [7:0] aoe = (p == 2) ? p2_alt_oe : alt_oe_i[p*8 +: 8];
    wire [7:0] val = func_q[p] & aval | ~func_q[p] & out_data_q[p]; // RULE6 RULE9
    wire [7:0] en = dir_q[p] & (func_q[p] & aoe | ~func_q[p]); // RULE8
    wire [7:0] od = otype_q[p];
    assign pin_o[p*8 +: 8] = val & ~od & msk; // RULE5 RULE10
    assign pin_oe_o[p*8 +: 8] = en & (~od | ~val) & msk; // RULE10
    assign pin_pullup_o[p*8 +: 8] = pullup_q[p] & (~dir_q[p] | od) & msk; // RULE11
  end

  // ==========================================================================
  // Port P1 and P4 secondary inputs.
  // These inputs follow the synchronised pad level whatever the direction,
  // so the peripherals behind them see the port's own drive in output mode.
  assign ext_reset_n_o = pin_sync_q[8]; // RULE13
  assign stop_release_o = pin_sync_q[9];
  assign ext_irq_f_o = pin_sync_q[9];
  assign ext_irq_a_o = pin_sync_q[10];
  assign ext_irq_b_o = pin_sync_q[11];
  assign analog_in_o = pin_sync_q[31:24]; // RULE16
  assign key_wakeup_o = pin_sync_q[31:24];

endmodule : gpio_bank

// ### logic/gpio_bank_pkg.sv
// Constants for the parallel port bank: register map, field layout and reset values.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package gpio_bank_pkg;
  // ==========================================================================
  // Bank shape
  localparam int NUM_PORTS = 8;
  localparam int PORT_W = 8;
  localparam int TOTAL_PINS = 40;
  // Implemented pin masks per port, index 0..7 = P0,P1,P2,P4,P7,P8,P9,PB.
  localparam logic [63:0] PORT_MASKS = 64'hF0_03_03_FF_FF_FF_0F_0F;
  // Bits 0 and 1 of the first port belong to the fast oscillator.
  localparam logic [7:0] OSC_RESERVED = 8'h03;
  // ==========================================================================
  // Register map: each port has a block of 8 words; stride in bytes.
  localparam logic [7:0] PORT_STRIDE = 8'h20;
  localparam logic [4:0] OFS_OUTPUT_DATA = 5'h00;
  localparam logic [4:0] OFS_PIN_STATE = 5'h04;
  localparam logic [4:0] OFS_DIRECTION = 5'h08;
  localparam logic [4:0] OFS_FUNCTION_SELECT = 5'h0C;
  localparam logic [4:0] OFS_OUTPUT_TYPE = 5'h10;
  localparam logic [4:0] OFS_PULLUP_SELECT = 5'h14;
  localparam logic [8:0] OFS_SERIAL_PIN_SELECT = 9'h100;
  localparam logic [8:0] OFS_UART_PIN_CONFIG = 9'h104;
  // ==========================================================================
  // Serial pin select fields.
  localparam int SRF_LSB = 0;
  localparam int SRG_BIT = 2;
  localparam logic [1:0] SRF_CLOCKED = 2'h1;
  localparam logic [1:0] SRF_ALT = 2'h2;
  localparam int UART_SWAP_BIT = 0;
  // ==========================================================================
  // Reset values: all inputs, plain port, push-pull, no pull-up.
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [2:0] RST_SERIAL = 3'h0;
  localparam logic RST_SWAP = 1'b0;
endpackage : gpio_bank_pkg

// ### verif/gpio_bank_assertions.sv
// Checker for the port bank: bus handshake and pad outputs.
// Assumes ce_i is held high by the bench.
module gpio_bank_chk (
  // Clock and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // Pads
  input wire logic [63:0] pin_i,
  input wire logic [63:0] pin_o,
  input wire logic [63:0] pin_oe_o,
  input wire logic [63:0] pin_pullup_o,
  input wire logic ext_irq_a_o,
  input wire logic [7:0] analog_in_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  ack_latency_a: assert property (cyc_i && stb_i && ce_i && !ack_o && !err_o |=> ack_o ^ err_o)
    else $error("no single answer one cycle after request");
  ack_cause_a: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
    else $error("answer without request");
  read_data_a: assert property (!(ack_o && !we_i) |-> dat_o == 32'h0)
    else $error("read data outside read answer");
  osc_pins_a: assert property (pin_oe_o[1:0] == 2'h0)
    else $error("oscillator pin driven");
  pullup_drive_a: assert property ((pin_oe_o & pin_o & pin_pullup_o) == 64'h0)
    else $error("pull-up on push-pull high");
  analog_sync_a: assert property (!$past(rst_i) && !$past(rst_i, 2)
    |-> analog_in_o == $past(pin_i[31:24], 2)) else $error("analog input lag wrong");
  irq_sync_a: assert property (!$past(rst_i) && !$past(rst_i, 2)
    |-> ext_irq_a_o == $past(pin_i[10], 2)) else $error("interrupt input lag wrong");
endmodule : gpio_bank_chk
bind gpio_bank gpio_bank_chk u_chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .dat_o,
  .ack_o, .err_o, .pin_i, .pin_o, .pin_oe_o, .pin_pullup_o, .ext_irq_a_o, .analog_in_o);

// ### verif/board_model.sv
// Board circuitry at the pads: drivers, pull-ups, floating lines.
// Assumes the bench sets which lines the board drives.
module board_model (
  input wire logic clk_i,
  input wire logic [63:0] pin_o,
  input wire logic [63:0] pin_oe_o,
  input wire logic [63:0] pin_pullup_o,
  input wire logic [63:0] ext_val_i,
  input wire logic [63:0] ext_en_i,
  output logic [63:0] pin_lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] float_q = 64'h0;
  // A floating line toggles, so a stale value never looks right.
  always @(posedge clk_i) float_q <= ~float_q;
  assign pin_lvl_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i)
    | (~pin_oe_o & ~ext_en_i & (pin_pullup_o | float_q));
endmodule : board_model

// ### verif/gpio_bank_tb.sv
// Self-checking bench for the port bank.
// Assumes the board model resolves the pads.
module gpio_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, got_err;
  logic uart_txd_i = 1'b0, serial_out_pin_i = 1'b0, ack_o, err_o;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o;
  logic [3:0] sel_i = 4'h0;
  logic [63:0] alt_out_i = 64'h0, alt_oe_i = 64'h0, ext_val = 64'h0, ext_en = 64'h0;
  logic [63:0] pin_lvl, pin_o, pin_oe_o, pin_pullup_o;
  logic [63:0] msk = gpio_bank_pkg::PORT_MASKS & ~{56'h0, gpio_bank_pkg::OSC_RESERVED};
  logic [7:0] rnd = 8'h51, m, dq[8];
  logic [31:0] exp_q[$];
  int n_errors = 0, n_tests = 0, bt[4] = '{16, 17, 16, 19};
  always #20 clk_i = ~clk_i;
  board_model board (.clk_i, .pin_o, .pin_oe_o, .pin_pullup_o, .ext_val_i(ext_val),
    .ext_en_i(ext_en), .pin_lvl_o(pin_lvl));
  gpio_bank DUT (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .err_o, .pin_i(pin_lvl), .pin_o, .pin_oe_o, .pin_pullup_o, .alt_out_i,
    .alt_oe_i, .uart_txd_i, .uart_rxd_o(), .serial_out_pin_i, .serial_clock_pin_i(1'b1),
    .serial_clock_oe_i(1'b0), .serial_in_pin_o(), .serial_clock_pin_o(),
    .twowire_clock_pin_i(1'b1), .twowire_data_pin_i(1'b1), .twowire_clock_pin_o(),
    .twowire_data_pin_o(), .ext_reset_n_o(), .ext_irq_a_o(), .ext_irq_b_o(), .ext_irq_f_o(),
    .stop_release_o(), .analog_in_o(), .key_wakeup_o());
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : chk
  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (!(ack_o || err_o) && i < 20);
    got_err = err_o;
    if (i >= 20) begin
      n_errors++;
      test_done();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask : rd
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      chk({32'h0, dat_o}, {32'h0, exp_q.pop_front()});
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int p = 0; p < 8; p++) begin
      for (int o = 0; o < 24; o += 8) rd(p * 32'h20 + o, 32'h0);
      m = msk[p*8+:8];
      rnd = lfsr(rnd);
      dq[p] = rnd & m;
      wb(1'b1, p * 32'h20 + 32'h8, 32'hFF, 4'hF);
      wb(1'b1, p * 32'h20, {24'h0, dq[p]}, 4'hF);
      chk(64'(pin_o[p*8+:8] & m), 64'(dq[p]));
      chk(64'(pin_oe_o[p*8+:8]), 64'(m));
      wb(1'b1, p * 32'h20, {24'h0, ~dq[p]}, 4'h0);
      rd(p * 32'h20, {24'h0, dq[p]});
      wb(1'b1, p * 32'h20 + 32'h8, 32'h0, 4'hF);
      chk(64'(pin_oe_o[p*8+:8]), 64'h0);
    end
    ext_en <= '1;
    for (int r = 0; r < 16; r++) begin
      rnd = lfsr(rnd);
      ext_val[(r%8)*8+:8] <= rnd & msk[(r%8)*8+:8];
      repeat (3) @(posedge clk_i);
      rd((r % 8) * 32'h20 + 32'h4, {24'h0, rnd & msk[(r%8)*8+:8]});
    end
    ext_en <= '0;
    wb(1'b1, 32'h68, 32'hFF, 4'hF);
    wb(1'b1, 32'h60, 32'h0F, 4'hF);
    wb(1'b1, 32'h70, 32'hFF, 4'hF);
    wb(1'b1, 32'h74, 32'hFF, 4'hF);
    chk(64'(pin_oe_o[31:24]), 64'hF0);
    chk(64'(pin_pullup_o[31:24]), 64'hFF);
    wb(1'b1, 32'h70, 32'h0, 4'hF);
    chk(64'(pin_oe_o[31:24]), 64'hFF);
    wb(1'b1, 32'h68, 32'h0, 4'hF);
    chk(64'(pin_pullup_o[31:24]), 64'hFF);
    alt_out_i <= {8{rnd}};
    alt_oe_i <= '1;
    wb(1'b1, 32'h88, 32'hFF, 4'hF);
    wb(1'b1, 32'h8C, 32'hFF, 4'hF);
    chk(64'(pin_o[39:32]), 64'(rnd));
    wb(1'b1, 32'h8C, 32'h0, 4'hF);
    chk(64'(pin_o[39:32]), 64'(dq[4]));
    wb(1'b1, 32'h40, 32'hFF, 4'hF);
    wb(1'b1, 32'h48, 32'h0B, 4'hF);
    wb(1'b1, 32'h4C, 32'h0B, 4'hF);
    for (int k = 0; k < 4; k++) begin
      uart_txd_i <= (k > 1);
      serial_out_pin_i <= (k < 2);
      wb(1'b1, 32'h104, {31'h0, k == 1}, 4'hF);
      wb(1'b1, 32'h100, {30'h0, k == 2, k == 3}, 4'hF);
      chk(64'({pin_oe_o[bt[k]], pin_o[bt[k]]}), 64'h2);
    end
    wb(1'b1, 32'h200, 32'h0, 4'hF);
    chk(64'(got_err), 64'h1);
    test_done();
  end
endmodule : gpio_bank_tb
